// ### verilog/operand_lane_select.v
// Purpose: route four operand buses into the sixteen multiplier operand slots
// Assumes: buses and codes come from logic on core_clk; codes change only when idle
// Notes: one register stage; int16 operands sit in the first slot of each group of four
`timescale 1ns/1ps
`include "operand_lane_select_regs.vh"
module operand_lane_select (
   input wire core_clk,
   input wire rst,
   input wire [4:0] low_code,
   input wire [5:0] high_code,
   input wire narrow_split,
   input wire in_valid,
   input wire [`BUS_W-1:0] a_low,
   input wire [`BUS_W-1:0] b_low,
   input wire [`BUS_W-1:0] a_high,
   input wire [`BUS_W-1:0] b_high,
   output reg [`SLOTS*`SLOT_W-1:0] op_a,
   output reg [`SLOTS*`SLOT_W-1:0] op_b,
   output reg [`SLOTS-1:0] mult_used,
   output reg [4:0] low_width,
   output reg [4:0] high_width,
   output reg low_code_bad,
   output reg high_code_bad,
   output reg [5:0] product_count,
   output reg out_valid
);
   // descriptor: {known, width[4:0], a_base[6:0], b_base[6:0], count[4:0]}
   function [`DESC_W-1:0] lane_desc;
      input [5:0] code;
      input high;
      begin
         lane_desc = {`DESC_W{1'b0}};
         if (!high) begin
            case (code) // RQ2
               `CODE_INT8_X1: lane_desc = {1'b1, `LANE_W8, 7'h00, 7'h20, 5'h04}; // RQ4
               `CODE_INT8_X2: lane_desc = {1'b1, `LANE_W8, 7'h00, 7'h00, 5'h08}; // RQ5
               `CODE_INT7_X1: lane_desc = {1'b1, `LANE_W7, 7'h00, 7'h23, 5'h05}; // RQ8
               `CODE_INT7_X2: lane_desc = {1'b1, `LANE_W7, 7'h00, 7'h00, 5'h08}; // RQ9
               `CODE_INT6_X1: lane_desc = {1'b1, `LANE_W6, 7'h00, 7'h24, 5'h06}; // RQ12
               `CODE_INT6_X2: lane_desc = {1'b1, `LANE_W6, 7'h00, 7'h00, 5'h08}; // RQ13
               `CODE_INT16_X1: lane_desc = {1'b1, `LANE_W16, 7'h00, 7'h20, 5'h02}; // RQ18
               `CODE_INT16_X2: lane_desc = {1'b1, `LANE_W16, 7'h00, 7'h00, 5'h02}; // RQ19
               default: lane_desc = {`DESC_W{1'b0}};
            endcase
         end else begin
            case (code) // RQ2
               // one-times codes and int8 x2 leave the high bank idle
               `CODE_INT8_X1: lane_desc = {1'b1, `LANE_W8, 7'h00, 7'h00, 5'h00}; // RQ4
               `CODE_INT8_X2: lane_desc = {1'b1, `LANE_W8, 7'h00, 7'h00, 5'h00}; // RQ5
               `CODE_INT7_X1: lane_desc = {1'b1, `LANE_W7, 7'h00, 7'h00, 5'h00}; // RQ8
               `CODE_INT6_X1: lane_desc = {1'b1, `LANE_W6, 7'h00, 7'h00, 5'h00}; // RQ12
               `CODE_INT16_X1: lane_desc = {1'b1, `LANE_W16, 7'h00, 7'h00, 5'h00}; // RQ18
               `CODE_INT7_X2: lane_desc = {1'b1, `LANE_W7, 7'h38, 7'h38, 5'h02}; // RQ9
               `CODE_INT6_X2: lane_desc = {1'b1, `LANE_W6, 7'h30, 7'h30, 5'h04}; // RQ13
               `CODE_INT16_X2: lane_desc = {1'b1, `LANE_W16, 7'h20, 7'h20, 5'h02}; // RQ19
               `CODE_INT8_SPLIT: lane_desc = {1'b1, `LANE_W8, 7'h00, 7'h20, 5'h04}; // RQ7
               `CODE_INT8_X4: lane_desc = {1'b1, `LANE_W8, 7'h00, 7'h00, 5'h08}; // RQ6
               `CODE_INT7_SPLIT: lane_desc = {1'b1, `LANE_W7, 7'h00, 7'h23, 5'h05}; // RQ11
               `CODE_INT7_X4: lane_desc = {1'b1, `LANE_W7, 7'h00, 7'h00, 5'h08}; // RQ10
               `CODE_INT6_SPLIT: lane_desc = {1'b1, `LANE_W6, 7'h00, 7'h24, 5'h06}; // RQ15
               `CODE_INT6_X4: lane_desc = {1'b1, `LANE_W6, 7'h00, 7'h00, 5'h08}; // RQ14
               `CODE_INT16_SPLIT: lane_desc = {1'b1, `LANE_W16, 7'h00, 7'h20, 5'h02}; // RQ20
               `CODE_INT16_COMPACT: lane_desc = {1'b1, `LANE_W16, 7'h00, 7'h00, 5'h02}; // RQ21
               default: lane_desc = {`DESC_W{1'b0}};
            endcase
         end
      end
   endfunction

   // each bank decodes its own code, so the halves can run different formats
   wire [`DESC_W-1:0] desc_low;
   wire [`DESC_W-1:0] desc_high;
   assign desc_low = lane_desc({1'b0, low_code}, 1'b0); // RQ3
   assign desc_high = lane_desc(high_code, 1'b1); // RQ3

   wire [`SLOTS*`SLOT_W-1:0] next_op_a;
   wire [`SLOTS*`SLOT_W-1:0] next_op_b;
   wire [`SLOTS-1:0] next_mult_used;

   genvar g;
   genvar j;
   generate
      for (g = 0; g < 2; g = g + 1) begin : bank
         wire [`DESC_W-1:0] d;
         wire [4:0] w;
         wire [6:0] a_base;
         wire [6:0] b_base;
         wire [4:0] n;
         wire wide;
         wire [`BUS_W-1:0] bus_a;
         wire [`BUS_W-1:0] bus_b;
         assign d = (g == 1) ? desc_high : desc_low;
         assign w = d[23:19];
         assign a_base = d[18:12];
         assign b_base = d[11:5];
         assign n = d[4:0];
         assign wide = (w == `LANE_W16);
         assign bus_a = (g == 1) ? a_high : a_low; // RQ2
         assign bus_b = (g == 1) ? b_high : b_low; // RQ2
         for (j = 0; j < `BANK_SLOTS; j = j + 1) begin : slot
            localparam [4:0] SLOT_IDX = j;
            localparam [4:0] GROUP_IDX = j / `GROUP_SLOTS;
            localparam [2:0] LANE_IDX = j;
            localparam [2:0] WIDE_IDX = j / `GROUP_SLOTS;
            localparam GROUP_HEAD = ((j % `GROUP_SLOTS) == 0);
            wire active;
            wire group_busy;
            wire [2:0] index;
            // an int16 operand occupies a whole group of four multipliers
            assign active = wide ? (GROUP_HEAD && (GROUP_IDX < n)) : (SLOT_IDX < n); // RQ1
            assign group_busy = wide ? (GROUP_IDX < n) : (SLOT_IDX < n);
            assign index = wide ? WIDE_IDX : LANE_IDX;
            assign next_mult_used[g*`BANK_SLOTS+j] = group_busy;
            lane_extract a_lane (
               .bus(bus_a),
               .lane_width(w),
               .base(a_base),
               .index(index),
               .active(active),
               .lane(next_op_a[(g*`BANK_SLOTS+j)*`SLOT_W +: `SLOT_W])
            );
            lane_extract b_lane (
               .bus(bus_b),
               .lane_width(w),
               .base(b_base),
               .index(index),
               .active(active),
               .lane(next_op_b[(g*`BANK_SLOTS+j)*`SLOT_W +: `SLOT_W])
            );
         end
      end
   endgenerate

   // int4 and int3 pack two values per lane; each multiplier then yields two products
   wire low_splits;
   wire high_splits;
   wire [5:0] low_products;
   wire [5:0] high_products;
   wire [5:0] next_product_count;
   assign low_splits = narrow_split &&
      (desc_low[23:19] == `LANE_W8 || desc_low[23:19] == `LANE_W6); // RQ16 RQ17
   assign high_splits = narrow_split &&
      (desc_high[23:19] == `LANE_W8 || desc_high[23:19] == `LANE_W6); // RQ16 RQ17
   assign low_products = low_splits ? {desc_low[4:0], 1'b0} : {1'b0, desc_low[4:0]}; // RQ16
   assign high_products = high_splits ? {desc_high[4:0], 1'b0} : {1'b0, desc_high[4:0]}; // RQ17
   assign next_product_count = low_products + high_products;

   // unknown codes give zero lanes and a flag; routing is not guaranteed for them
   always @(posedge core_clk) begin
      if (rst) begin
         op_a <= {`SLOTS*`SLOT_W{`OUT_RST}};
         op_b <= {`SLOTS*`SLOT_W{`OUT_RST}};
         mult_used <= {`SLOTS{`OUT_RST}};
         low_width <= 5'h00;
         high_width <= 5'h00;
         low_code_bad <= `OUT_RST;
         high_code_bad <= `OUT_RST;
         product_count <= 6'h00;
         out_valid <= `OUT_RST;
      end else begin
         op_a <= next_op_a;
         op_b <= next_op_b;
         mult_used <= next_mult_used;
         low_width <= desc_low[23:19];
         high_width <= desc_high[23:19];
         low_code_bad <= ~desc_low[24]; // RQ23
         high_code_bad <= ~desc_high[24]; // RQ23
         product_count <= next_product_count;
         out_valid <= in_valid;
      end
   end
endmodule

// ### verilog/operand_lane_select_regs.vh
// Purpose: constants for the operand lane selection stage
// Assumes: included by bare name from the design files
// Notes: mapping codes are 6 bits wide; the low bank uses only codes below 6'h20
// Functional notes
// [RQ1] lane width follows configured number format
// [RQ2] low code feeds 0-7, high 8-15
// [RQ3] low and high codes are independent
// [RQ4] int8 x1: a[31:0], b[63:32], high unused
// [RQ5] int8 x2: eight bytes from low [63:0]
// [RQ6] int8 x4: high [63:0] feeds 8-15
// [RQ7] int8 split: high mirrors low x1 placement
// [RQ8] int7 x1: a[34:0], b[69:35]
// [RQ9] int7 x2: low [55:0], 8-9 high top
// [RQ10] int7 x4: high [55:0] feeds 8-15
// [RQ11] int7 split: high mirrors low x1 placement
// [RQ12] int6 x1: a[35:0], b[71:36]
// [RQ13] int6 x2: low [47:0], high [71:48]
// [RQ14] int6 x4: high [47:0] feeds 8-15
// [RQ15] int6 split: high mirrors low x1 placement
// [RQ16] int4 uses int8 codes, doubled products
// [RQ17] int3 uses int6 codes, doubled products
// [RQ18] int16 x1: a[31:0], b[63:32]
// [RQ19] int16 x2: low [31:0], high [63:32]
// [RQ20] int16 split: high a[31:0], b[63:32]
// [RQ21] int16 compact: all buses use [31:0]
// [RQ22] driver zeroes unused bit positions
// [RQ23] codes static; unknown codes undefined
`ifndef OPERAND_LANE_SELECT_REGS_VH
`define OPERAND_LANE_SELECT_REGS_VH

`define CODE_INT8_X1       6'h00
`define CODE_INT8_X2       6'h01
`define CODE_INT7_X1       6'h07
`define CODE_INT7_X2       6'h08
`define CODE_INT6_X1       6'h0a
`define CODE_INT6_X2       6'h0b
`define CODE_INT16_X1      6'h11
`define CODE_INT16_X2      6'h12
`define CODE_INT8_SPLIT    6'h20
`define CODE_INT8_X4       6'h21
`define CODE_INT7_SPLIT    6'h27
`define CODE_INT7_X4       6'h28
`define CODE_INT6_SPLIT    6'h2a
`define CODE_INT6_X4       6'h2b
`define CODE_INT16_SPLIT   6'h31
`define CODE_INT16_COMPACT 6'h32

`define LANE_W8  5'h08
`define LANE_W7  5'h07
`define LANE_W6  5'h06
`define LANE_W16 5'h10

`define BUS_W        72
`define SLOT_W       16
`define SLOTS        16
`define BANK_SLOTS   8
`define GROUP_SLOTS  4
`define DESC_W       25

`define OUT_RST      1'b0
`define STAGE_LATENCY 1

`endif

// ### verilog/lane_extract.v
// Purpose: pull one operand lane of variable width out of a 72-bit bus
// Assumes: width is one of 6, 7, 8 or 16; offset stays inside the bus
// Notes: purely combinational; the caller registers the result
`timescale 1ns/1ps
`include "operand_lane_select_regs.vh"
module lane_extract (
   input wire [`BUS_W-1:0] bus,
   input wire [4:0] lane_width,
   input wire [6:0] base,
   input wire [2:0] index,
   input wire active,
   output wire [`SLOT_W-1:0] lane
);
   wire [7:0] step;
   wire [7:0] offset;
   wire [`BUS_W-1:0] shifted;
   reg [`SLOT_W-1:0] mask;

   assign step = {3'h0, lane_width} * {5'h00, index};
   assign offset = {1'b0, base} + step;
   assign shifted = bus >> offset;

   // mask keeps the upper bits of narrow lanes at zero
   always @* begin
      case (lane_width)
         `LANE_W8: mask = 16'h00ff;
         `LANE_W7: mask = 16'h007f;
         `LANE_W6: mask = 16'h003f;
         `LANE_W16: mask = 16'hffff;
         default: mask = 16'h0000;
      endcase
   end

   assign lane = shifted[`SLOT_W-1:0] & mask & {`SLOT_W{active}}; // RQ1
endmodule

// ### tb/lane_source.sv
// Purpose: far-side source that packs operand lanes onto the four buses
// Assumes: lane width, count and base of each bus come from the bench
// Notes: every bit outside the packed lanes is driven 0
`timescale 1ns/1ps
module lane_source (
   input wire logic [4:0] w,
   input wire logic [3:0] nl,
   input wire logic [6:0] al,
   input wire logic [6:0] bl,
   input wire logic [3:0] nh,
   input wire logic [6:0] ah,
   input wire logic [6:0] bh,
   input wire logic [7:0] seed,
   output logic [71:0] a_low,
   output logic [71:0] b_low,
   output logic [71:0] a_high,
   output logic [71:0] b_high
);
   function automatic logic [15:0] val(input int k, input int b);
      return (seed * 16'h0101 + k * 16'h01d3 + b * 16'h0537) & ((17'h1 << w) - 1);
   endfunction
   // a w-bit lane may hold two packed narrow values; the bits are arbitrary
   always_comb begin
      logic [15:0] v;
      v = '0;
      a_low = '0;
      b_low = '0;
      a_high = '0;
      b_high = '0;
      for (int k = 0; k < 8; k++)
         for (int j = 0; j < 16; j++)
            if (j < w) begin
               v = val(k, 0);
               if (k < nl) a_low[al + w * k + j] = v[j];
               v = val(k, 1);
               if (k < nl) b_low[bl + w * k + j] = v[j];
               v = val(k + 8, 0);
               if (k < nh) a_high[ah + w * k + j] = v[j];
               v = val(k + 8, 1);
               if (k < nh) b_high[bh + w * k + j] = v[j];
            end
   end
endmodule

// ### tb/operand_lane_select_sva.sv
// Purpose: port-level checks of the lane routing
// Assumes: outputs follow inputs after exactly one edge
// Notes: spot checks lanes in nine of the sixteen modes and one unknown code; the bench covers the rest
`timescale 1ns/1ps
`include "operand_lane_select_regs.vh"
module operand_lane_select_sva (
   input wire core_clk,
   input wire rst,
   input wire [4:0] low_code,
   input wire [5:0] high_code,
   input wire [`BUS_W-1:0] a_low,
   input wire [`BUS_W-1:0] b_low,
   input wire [`BUS_W-1:0] a_high,
   input wire [`BUS_W-1:0] b_high,
   input wire [`SLOTS*`SLOT_W-1:0] op_a,
   input wire [`SLOTS*`SLOT_W-1:0] op_b,
   input wire [`SLOTS-1:0] mult_used,
   input wire [4:0] low_width,
   input wire low_code_bad,
   input wire [5:0] product_count
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   a_int8_single: assert property (
      low_code == 5'h00 |=> op_a[15:0] == {8'h00, $past(a_low[7:0])}
      && op_b[63:48] == {8'h00, $past(b_low[63:56])} && mult_used[7:0] == 8'h0f)
      else $error("int8 x1 lane wrong");
   a_int8_quad: assert property (
      high_code == 6'h21 |=> op_b[255:240] == {8'h00, $past(b_high[63:56])}
      && mult_used[15:8] == 8'hff) else $error("int8 x4 lane wrong");
   a_int8_split: assert property (
      high_code == 6'h20 |=> op_b[191:176] == {8'h00, $past(b_high[63:56])})
      else $error("int8 split lane wrong");
   a_int7_single: assert property (
      low_code == 5'h07 |=> low_width == 5'h07
      && op_b[79:64] == {9'h000, $past(b_low[69:63])}) else $error("int7 x1 lane wrong");
   a_int7_double: assert property (
      high_code == 6'h08 |=> op_a[159:144] == {9'h000, $past(a_high[69:63])})
      else $error("int7 x2 high lane wrong");
   a_int6_double: assert property (
      high_code == 6'h0b |=> op_a[191:176] == {10'h000, $past(a_high[71:66])})
      else $error("int6 x2 high lane wrong");
   a_int6_quad: assert property (
      high_code == 6'h2b |=> op_b[255:240] == {10'h000, $past(b_high[47:42])})
      else $error("int6 x4 lane wrong");
   a_int16_double: assert property (
      high_code == 6'h12 |=> op_a[143:128] == $past(a_high[47:32])
      && op_b[207:192] == $past(b_high[63:48])) else $error("int16 x2 lane wrong");
   a_int16_compact: assert property (
      low_code == 5'h12 && high_code == 6'h32 |=> product_count == 6'h04
      && op_a[207:192] == $past(a_high[31:16])) else $error("int16 compact wrong");
   a_low_unknown: assert property (
      low_code == 5'h05 |=> low_code_bad && low_width == 5'h00 && op_a[127:0] == 128'h0)
      else $error("unknown low code not refused");
endmodule
bind operand_lane_select operand_lane_select_sva i_sva (.core_clk(core_clk), .rst(rst),
   .low_code(low_code), .high_code(high_code), .a_low(a_low), .b_low(b_low),
   .a_high(a_high), .b_high(b_high), .op_a(op_a), .op_b(op_b), .mult_used(mult_used),
   .low_width(low_width), .low_code_bad(low_code_bad), .product_count(product_count));

// ### tb/test_operand_lane_select.sv
// Purpose: self-checking bench for the operand lane selection stage
// Assumes: one edge from inputs to registered outputs
// Notes: idle high bank is expected to report the low bank width
`timescale 1ns/1ps
module test_operand_lane_select;
   logic core_clk = 0, rst = 1, narrow_split = 0, in_valid = 0;
   logic [4:0] low_code = 0, w = 8;
   logic [5:0] high_code = 0;
   logic [3:0] nl = 0, nh = 0;
   logic [6:0] al = 0, bl = 0, ah = 0, bh = 0;
   logic [7:0] seed = 0;
   wire [71:0] a_low, b_low, a_high, b_high;
   wire [255:0] op_a, op_b;
   wire [15:0] mult_used;
   wire [4:0] low_width, high_width;
   wire [5:0] product_count;
   wire low_code_bad, high_code_bad, out_valid;
   int fails = 0, cmp_count = 0;
   always #5 core_clk = ~core_clk;
   lane_source i_src (.w(w), .nl(nl), .al(al), .bl(bl), .nh(nh), .ah(ah), .bh(bh),
      .seed(seed), .a_low(a_low), .b_low(b_low), .a_high(a_high), .b_high(b_high));
   operand_lane_select i_dut (.core_clk(core_clk), .rst(rst), .low_code(low_code),
      .high_code(high_code), .narrow_split(narrow_split), .in_valid(in_valid),
      .a_low(a_low), .b_low(b_low), .a_high(a_high), .b_high(b_high), .op_a(op_a),
      .op_b(op_b), .mult_used(mult_used), .low_width(low_width), .high_width(high_width),
      .low_code_bad(low_code_bad), .high_code_bad(high_code_bad),
      .product_count(product_count), .out_valid(out_valid));
   task automatic chk(input logic [255:0] seen, input logic [255:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [15:0] lv(input int k, input int b);
      return (seed * 16'h0101 + k * 16'h01d3 + b * 16'h0537) & ((17'h1 << w) - 1);
   endfunction
   task automatic step(input logic [4:0] lc, input logic [5:0] hc, input logic [4:0] lw,
      input int n0, input int a0, input int b0, input int n1, input int a1, input int b1,
      input logic ns);
      logic [255:0] ea, eb;
      logic [15:0] eu;
      int s, j, m;
      @(posedge core_clk);
      #1;
      {low_code, high_code, w, narrow_split, in_valid} = {lc, hc, lw, ns, 1'b1};
      {nl, al, bl, nh, ah, bh} = {4'(n0), 7'(a0), 7'(b0), 4'(n1), 7'(a1), 7'(b1)};
      seed = seed + 8'h35;
      ea = '0;
      eb = '0;
      eu = '0;
      m = (ns && (lw == 8 || lw == 6)) ? 2 : 1;
      for (int k = 0; k < n0 + n1; k++) begin
         j = k < n0 ? k : k - n0;
         s = (k < n0 ? 0 : 8) + (lw == 16 ? 4 : 1) * j;
         ea[s*16 +: 16] = lv(k < n0 ? j : j + 8, 0);
         eb[s*16 +: 16] = lv(k < n0 ? j : j + 8, 1);
         eu |= (lw == 16 ? 16'h000f : 16'h0001) << s;
      end
      @(posedge core_clk);
      #1;
      chk(op_a, ea);
      chk(op_b, eb);
      chk(mult_used, eu);
      chk({low_width, high_width, product_count}, {lw, lw, 6'(m * (n0 + n1))});
      chk({low_code_bad, high_code_bad, out_valid}, 3'h1);
   endtask
   // codes change only between steps, never inside one
   task automatic t_int8();
      step(5'h00, 6'h00, 8, 4, 0, 32, 0, 0, 0, 0);
      step(5'h01, 6'h01, 8, 8, 0, 0, 0, 0, 0, 1);
      step(5'h01, 6'h21, 8, 8, 0, 0, 8, 0, 0, 1);
      step(5'h00, 6'h20, 8, 4, 0, 32, 4, 0, 32, 0);
      $display("test int8 done");
   endtask
   task automatic t_int7();
      step(5'h07, 6'h07, 7, 5, 0, 35, 0, 0, 0, 0);
      step(5'h08, 6'h08, 7, 8, 0, 0, 2, 56, 56, 1);
      step(5'h08, 6'h28, 7, 8, 0, 0, 8, 0, 0, 0);
      step(5'h07, 6'h27, 7, 5, 0, 35, 5, 0, 35, 0);
      $display("test int7 done");
   endtask
   task automatic t_int6();
      step(5'h0a, 6'h0a, 6, 6, 0, 36, 0, 0, 0, 1);
      step(5'h0b, 6'h0b, 6, 8, 0, 0, 4, 48, 48, 0);
      step(5'h0b, 6'h2b, 6, 8, 0, 0, 8, 0, 0, 1);
      step(5'h0a, 6'h2a, 6, 6, 0, 36, 6, 0, 36, 0);
      $display("test int6 done");
   endtask
   task automatic t_int16();
      step(5'h11, 6'h11, 16, 2, 0, 32, 0, 0, 0, 0);
      step(5'h12, 6'h12, 16, 2, 0, 0, 2, 32, 32, 0);
      step(5'h11, 6'h31, 16, 2, 0, 32, 2, 0, 32, 0);
      step(5'h12, 6'h32, 16, 2, 0, 0, 2, 0, 0, 1);
      $display("test int16 done");
   endtask
   task automatic t_bad();
      @(posedge core_clk);
      #1;
      {low_code, high_code, nl, nh} = {5'h05, 6'h3f, 4'h0, 4'h0};
      @(posedge core_clk);
      #1;
      chk(op_a | op_b, 256'h0);
      chk({mult_used, low_width, high_width, low_code_bad, high_code_bad}, 28'h3);
      rst = 1;
      in_valid = 0;
      @(posedge core_clk);
      #1;
      rst = 0;
      chk(op_a | op_b, 256'h0);
      chk({mult_used, low_width, high_width, product_count, low_code_bad, high_code_bad,
         out_valid}, 35'h0);
      // first edge after a mid-run reset: codes still unknown, qualifier now low
      @(posedge core_clk);
      #1;
      chk({low_code_bad, high_code_bad, out_valid}, 3'h6);
      chk({mult_used, low_width, high_width, product_count}, 32'h0);
      $display("test refusal and reset done");
   endtask
   task automatic final_report();
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge core_clk);
      #1;
      rst = 0;
      t_int8();
      t_int7();
      t_int6();
      t_int16();
      t_bad();
      final_report();
   end
endmodule
